// File: core/risc_decode_privilege.sv
// instruction decoder: word intake, operand forms, privilege faults, alu staging
// assumes fetch and execution share i_mclk; software reaches control over avalon-mm
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps

// Overview of operation
// (RULE1) Eight general registers support literal, memory, logic, integer and compare use, no float.
// (RULE2) A general register pairs with any other register as either operand of a two-register instruction; here the pointer id 0x00 is illegal.
// (RULE3) Four alu registers support literal, memory, logic, integer and compare use.
// (RULE4) Arithmetic or logic on non-alu registers saves two alu registers, stages, executes, then restores.
// (RULE5) Float arithmetic runs on the four float registers only; other mixes are unspecified.
// (RULE6) Status bit 3 selects the level: clear is level 0 (most privileged), set is level 1.
// (RULE7) Level 0 may write every register directly except the instruction pointer.
// (RULE8) Level 1 writes only general, alu, float, stack and the three config registers.
// (RULE9) Task load at level 1 is not done and raises an illegal-instruction fault.
// (RULE10) Architecture interrupt handlers run at level 0 and may be invoked by software only from level 0.
// (RULE11) A level 1 software interrupt to a vector needing level 0 raises a privilege fault.
// (RULE12) Exactly fourteen instructions are recognised.
// (RULE13) The identifier is the low byte; each memory or literal operand takes one extension word.
// (RULE14) Source id sits in bits 15..8, target id in 23..16, bits 31..24 are zero.
// (RULE15) Register ids step by four from the pointer at 0x00 to the last float register at 0x6C.
// (RULE16) Unused opcodes, unknown register ids and unpermitted operand forms are illegal.
module risc_decode_privilege
(
    input  wire logic             i_mclk,
    input  wire logic             i_rstn,
    input  wire logic             i_word_valid,
    input  wire logic [31:0]      i_word,
    output logic                  o_word_ready,
    output dec_pkg::uop_t         o_uop,
    output logic                  o_uop_valid,
    input  wire logic             i_uop_ready,
    input  wire dec_pkg::av_req_t i_av,
    output dec_pkg::av_rsp_t      o_av,
    output logic                  o_priv_level
);
    import dec_pkg::*;

    dec_regs_t   r;
    dec_regs_t   n;
    logic [31:0] cur;
    logic [7:0]  op;
    logic [7:0]  sy;
    logic [7:0]  tx;
    form_t       sf;
    form_t       tf;
    logic        fok;
    logic        regs_ok;
    logic [1:0]  next_ext;
    reg_class_t  cs;
    reg_class_t  ct;
    fault_t      flt;
    logic        stage_need;
    logic        slot_free;
    logic        accept;
    logic [31:0] rd;
    logic [2:0]  flt_set;
    logic [2:0]  flt_clr;
    logic [7:0]  pa;
    logic [7:0]  pb;
    uop_t        u;

    // first word comes live from fetch while idle, from the latch afterwards
    assign cur = (r.state == ST_IDLE) ? i_word : r.word;

    // (RULE13) identifier in the low byte
    assign op = cur[7:0];
    // (RULE14) source and target fields
    assign sy = cur[15:8];
    assign tx = cur[23:16];

    reg_class u_src_class
    (
        .i_id    (sy),
        .o_class (cs)
    );

    reg_class u_tgt_class
    (
        .i_id    (tx),
        .o_class (ct)
    );

    priv_check u_priv_check
    (
        .i_op       (op),
        .i_priv     (r.priv),
        .i_tgt_form (tf),
        .i_tgt      (ct),
        .i_tgt_id   (tx),
        .i_vector   (sy),
        .i_vec_mask (r.vec_mask),
        .i_bad      (!regs_ok),
        .o_fault    (flt)
    );

    // lowest alu register not named by the instruction and not already taken
    function automatic logic [7:0] pick_alu(input logic [7:0] a, input logic [7:0] b, input logic [7:0] skip);
        logic [7:0] id;
        pick_alu = ID_ALU_FIRST;
        for (int k = ALU_COUNT - 1; k >= 0; k--)
        begin
            id = ID_ALU_FIRST + 8'(k * 4);
            if ((id != a) && (id != b) && (id != skip))
                pick_alu = id;
        end
    endfunction

    // ----------------------------------------------------------------
    // operand forms
    // ----------------------------------------------------------------
    always_comb
    begin
        sf  = FORM_NONE;
        tf  = FORM_NONE;
        fok = 1'b0;
        // (RULE12) fourteen identifiers, rest illegal
        case (op)
            copy_register_op:
            begin
                sf  = FORM_REG;
                tf  = (tx == 8'h00) ? FORM_MEM : FORM_REG;
                fok = (sy != 8'h00);
            end
            copy_literal_op:
            begin
                sf  = FORM_LIT;
                tf  = (tx == 8'h00) ? FORM_MEM : FORM_REG;
                fok = (sy == 8'h00);
            end
            copy_memory_op:
            begin
                sf  = (sy == 8'h00) ? FORM_MEM : FORM_REG;
                tf  = (tx == 8'h00) ? FORM_MEM : FORM_REG;
                fok = 1'b1;
            end
            // (RULE2) any register pair accepted except the pointer
            store_indirect_op, compare_op, arithmetic_op, logic_op:
            begin
                sf  = FORM_REG;
                tf  = FORM_REG;
                fok = (sy != 8'h00) && (tx != 8'h00);
            end
            conditional_branch_op, call_op, task_load_op:
            begin
                sf  = (sy == 8'h00) ? FORM_MEM : FORM_REG;
                fok = (tx == 8'h00);
            end
            software_interrupt_op:
                fok = (tx == 8'h00);
            subroutine_exit_op, misc_op_0c, nop_op:
                fok = (tx == 8'h00) && (sy == 8'h00);
            default:
                fok = 1'b0;
        endcase
        // (RULE14) top byte must be zero
        // (RULE16) unknown ids and bad forms
        regs_ok = fok && (cur[31:24] == 8'h00) && ((sf != FORM_REG) || cs.known)
                  && ((tf != FORM_REG) || ct.known);
        // (RULE13) one extension word per memory or literal
        next_ext = 2'((sf == FORM_MEM) || (sf == FORM_LIT)) + 2'(tf == FORM_MEM);
        // (RULE4) staging needed off the alu registers
        // (RULE5) float pairs go straight to the fpu
        stage_need = ((op == arithmetic_op) || (op == logic_op)) && !(cs.alu && ct.alu) && !(cs.fp && ct.fp);
        pa = pick_alu(sy, tx, 8'hFF);
        pb = pick_alu(sy, tx, pa);
        u.kind     = (flt == FAULT_NONE) ? UOP_EXEC : UOP_FAULT;
        u.op       = op;
        u.src_id   = sy;
        u.tgt_id   = tx;
        u.src_form = sf;
        u.tgt_form = tf;
        u.special  = (op == software_interrupt_op) ? sy : 8'h00;
        u.ext0     = r.ext0;
        u.ext1     = r.ext1;
        u.fault    = flt;
        u.fp_mode  = cs.fp && ct.fp;
    end

    // ----------------------------------------------------------------
    // avalon read mux
    // ----------------------------------------------------------------
    always_comb
    begin
        rd = 32'h0000_0000;
        case (i_av.address)
            // (RULE6) privilege bit shown at bit 3
            OFS_CTRL:     rd = {28'h000_0000, r.priv, 2'b00, r.ctrl_en};
            OFS_FAULT:    rd = {29'h0000_0000, r.fault};
            OFS_VEC_MASK: rd = r.vec_mask;
            OFS_STATE:    rd = {r.instr_count, 13'h0000, r.state};
            default:      rd = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n         = r;
        flt_set   = 3'b000;
        flt_clr   = 3'b000;
        accept    = i_word_valid && r.word_ready;
        slot_free = !r.uop_valid || i_uop_ready;
        if (r.uop_valid && i_uop_ready)
            n.uop_valid = 1'b0;
        case (r.state)
            ST_IDLE:
                if (accept)
                begin
                    n.word     = i_word;
                    n.ext_left = next_ext;
                    n.ext0     = 32'h0000_0000;
                    n.ext1     = 32'h0000_0000;
                    n.state    = (next_ext == 2'd0) ? ST_ISSUE : ST_EXT1;
                end
            ST_EXT1:
                if (accept)
                begin
                    n.ext0  = i_word;
                    n.state = (r.ext_left == 2'd2) ? ST_EXT2 : ST_ISSUE;
                end
            ST_EXT2:
                if (accept)
                begin
                    n.ext1  = i_word;
                    n.state = ST_ISSUE;
                end
            ST_ISSUE:
                if ((flt == FAULT_NONE) && stage_need)
                begin
                    n.state   = ST_STAGE;
                    n.step    = 3'd0;
                    n.stage_a = pa;
                    n.stage_b = pb;
                end
                else if (slot_free)
                begin
                    n.uop_valid   = 1'b1;
                    n.uop         = u;
                    n.state       = ST_IDLE;
                    n.instr_count = r.instr_count + 16'h0001;
                    if (flt != FAULT_NONE)
                        flt_set[flt - 2'd1] = 1'b1;
                end
            // (RULE4) save, load, execute, write back, restore
            ST_STAGE:
                if (slot_free)
                begin
                    n.uop_valid = 1'b1;
                    n.uop       = u;
                    n.step      = r.step + 3'd1;
                    case (r.step)
                        3'd0:
                        begin
                            n.uop.kind   = UOP_SAVE;
                            n.uop.src_id = r.stage_a;
                        end
                        3'd1:
                        begin
                            n.uop.kind   = UOP_SAVE;
                            n.uop.src_id = r.stage_b;
                        end
                        3'd2:
                        begin
                            n.uop.kind   = UOP_LOAD;
                            n.uop.tgt_id = r.stage_a;
                        end
                        3'd3:
                        begin
                            n.uop.kind   = UOP_LOAD;
                            n.uop.src_id = tx;
                            n.uop.tgt_id = r.stage_b;
                        end
                        3'd4:
                        begin
                            n.uop.src_id = r.stage_a;
                            n.uop.tgt_id = r.stage_b;
                        end
                        3'd5:
                        begin
                            n.uop.kind   = UOP_WRBACK;
                            n.uop.src_id = r.stage_b;
                        end
                        3'd6:
                        begin
                            n.uop.kind   = UOP_RESTORE;
                            n.uop.tgt_id = r.stage_a;
                        end
                        default:
                        begin
                            n.uop.kind   = UOP_RESTORE;
                            n.uop.tgt_id = r.stage_b;
                        end
                    endcase
                    if (r.step == STAGE_LAST)
                    begin
                        n.state       = ST_IDLE;
                        n.instr_count = r.instr_count + 16'h0001;
                    end
                end
            default:
                n.state = ST_IDLE;
        endcase
        // fetch stalls whenever disabled or busy issuing
        n.word_ready = r.ctrl_en && ((n.state == ST_IDLE) || (n.state == ST_EXT1) || (n.state == ST_EXT2));

        // one wait cycle, then the request is taken on the edge with waitrequest low
        if (r.av_wait)
        begin
            if (i_av.read || i_av.write)
            begin
                n.av_wait  = 1'b0;
                n.av_rdata = rd;
            end
        end
        else
        begin
            n.av_wait = 1'b1;
            if (i_av.write)
            begin
                case (i_av.address)
                    OFS_CTRL:
                    begin
                        n.ctrl_en = i_av.writedata[CTRL_EN_BIT];
                        // (RULE6) level select bit
                        n.priv    = i_av.writedata[PRIV_BIT];
                    end
                    OFS_FAULT:    flt_clr = i_av.writedata[FAULT_BITS-1:0];
                    OFS_VEC_MASK: n.vec_mask = i_av.writedata;
                    default:      n.av_wait = 1'b1;
                endcase
            end
        end
        // a fault in the clearing cycle stays set
        n.fault = (r.fault & ~flt_clr) | flt_set;
    end

    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
            r <= REGS_RESET;
        else
            r <= n;
    end

    assign o_word_ready = r.word_ready;
    assign o_uop        = r.uop;
    assign o_uop_valid  = r.uop_valid;
    assign o_av         = '{waitrequest: r.av_wait, readdata: r.av_rdata};
    assign o_priv_level = r.priv;

endmodule

// File: core/dec_pkg.sv
// shared types and constants of the instruction decoder with privilege checking
// assumes a single core clock; all numbers used by more than one file live here
package dec_pkg;

    // ----------------------------------------------------------------
    // register identifiers, steps of four
    // ----------------------------------------------------------------
    localparam logic [7:0] ID_STEP       = 8'h04;
    localparam logic [7:0] ID_IP         = 8'h00;
    localparam logic [7:0] ID_STACK      = 8'h20;
    localparam logic [7:0] ID_COMPARE_CFG = 8'h24;
    localparam logic [7:0] ID_LOGIC_CFG  = 8'h28;
    localparam logic [7:0] ID_ARITH_CFG  = 8'h2C;
    localparam logic [7:0] ID_GP_FIRST   = 8'h30;
    localparam logic [7:0] ID_GP_LAST    = 8'h4C;
    localparam logic [7:0] ID_ALU_FIRST  = 8'h50;
    localparam logic [7:0] ID_ALU_LAST   = 8'h5C;
    localparam logic [7:0] ID_FP_FIRST   = 8'h60;
    localparam logic [7:0] ID_FP_LAST    = 8'h6C;
    localparam int         GP_COUNT      = 8;
    localparam int         ALU_COUNT     = 4;
    localparam int         FP_COUNT      = 4;

    // ----------------------------------------------------------------
    // privilege and interrupts
    // ----------------------------------------------------------------
    localparam int         PRIV_BIT      = 3;
    localparam logic [7:0] ARCH_VEC_NUM  = 8'h20;
    localparam logic [7:0] USER_VEC_LAST = 8'h3F;

    // ----------------------------------------------------------------
    // avalon register map, byte addresses
    // ----------------------------------------------------------------
    localparam logic [4:0] OFS_CTRL      = 5'h00;
    localparam logic [4:0] OFS_FAULT     = 5'h04;
    localparam logic [4:0] OFS_VEC_MASK  = 5'h08;
    localparam logic [4:0] OFS_STATE     = 5'h0C;
    localparam int         CTRL_EN_BIT   = 0;
    localparam int         FAULT_BITS    = 3;
    localparam logic [2:0] STAGE_LAST    = 3'h7;

    typedef enum logic [7:0] {
        copy_register_op      = 8'h01,
        copy_literal_op       = 8'h02,
        copy_memory_op        = 8'h03,
        store_indirect_op     = 8'h04,
        compare_op            = 8'h05,
        conditional_branch_op = 8'h06,
        call_op               = 8'h07,
        subroutine_exit_op    = 8'h08,
        arithmetic_op         = 8'h09,
        logic_op              = 8'h0A,
        software_interrupt_op = 8'h0B,
        misc_op_0c            = 8'h0C,
        nop_op                = 8'h0D,
        task_load_op          = 8'h0E
    } op_t;

    typedef enum logic [1:0] {FORM_NONE = 2'b00, FORM_REG = 2'b01, FORM_MEM = 2'b10, FORM_LIT = 2'b11} form_t;
    typedef enum logic [1:0] {FAULT_NONE = 2'b00, FAULT_ILLEGAL = 2'b01, FAULT_PRIV = 2'b10,
                              FAULT_WRITE = 2'b11} fault_t;
    typedef enum logic [2:0] {UOP_EXEC = 3'b000, UOP_SAVE = 3'b001, UOP_LOAD = 3'b010, UOP_WRBACK = 3'b011,
                              UOP_RESTORE = 3'b100, UOP_FAULT = 3'b101} uop_kind_t;
    typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_EXT1 = 3'b001, ST_EXT2 = 3'b010, ST_ISSUE = 3'b011,
                              ST_STAGE = 3'b100} dec_state_t;

    typedef struct packed {
        logic known;
        logic ctrl;
        logic gp;
        logic alu;
        logic fp;
        logic user_wr;
    } reg_class_t;

    typedef struct packed {
        uop_kind_t   kind;
        logic [7:0]  op;
        logic [7:0]  src_id;
        logic [7:0]  tgt_id;
        form_t       src_form;
        form_t       tgt_form;
        logic [7:0]  special;
        logic [31:0] ext0;
        logic [31:0] ext1;
        fault_t      fault;
        logic        fp_mode;
    } uop_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } av_req_t;

    typedef struct packed {
        logic        waitrequest;
        logic [31:0] readdata;
    } av_rsp_t;

    typedef struct packed {
        dec_state_t  state;
        logic [31:0] word;
        logic [31:0] ext0;
        logic [31:0] ext1;
        logic [1:0]  ext_left;
        logic [2:0]  step;
        logic [7:0]  stage_a;
        logic [7:0]  stage_b;
        logic        word_ready;
        logic        uop_valid;
        uop_t        uop;
        logic        ctrl_en;
        logic        priv;
        logic [2:0]  fault;
        logic [31:0] vec_mask;
        logic [15:0] instr_count;
        logic        av_wait;
        logic [31:0] av_rdata;
    } dec_regs_t;

    localparam dec_regs_t REGS_RESET = '{state: ST_IDLE, av_wait: 1'b1, ctrl_en: 1'b1, default: '0};

endpackage

// File: core/reg_class.sv
// classifies one register identifier into its register group
// assumes identifiers come straight from an instruction word, unchecked
`timescale 1ns/1ps
module reg_class
(
    input  wire logic [7:0]          i_id,
    output dec_pkg::reg_class_t      o_class
);
    import dec_pkg::*;

    always_comb
    begin
        // (RULE15) four-step identifier map
        o_class.known   = (i_id[1:0] == 2'b00) && (i_id <= ID_FP_LAST);
        o_class.ctrl    = o_class.known && (i_id < ID_GP_FIRST);
        // (RULE1) eight general registers
        o_class.gp      = o_class.known && (i_id >= ID_GP_FIRST) && (i_id <= ID_GP_LAST);
        // (RULE3) four alu registers
        o_class.alu     = o_class.known && (i_id >= ID_ALU_FIRST) && (i_id <= ID_ALU_LAST);
        // (RULE5) four float registers
        o_class.fp      = o_class.known && (i_id >= ID_FP_FIRST);
        // (RULE8) writable at level 1
        o_class.user_wr = o_class.gp || o_class.alu || o_class.fp || (i_id == ID_STACK)
                          || (i_id == ID_COMPARE_CFG) || (i_id == ID_LOGIC_CFG) || (i_id == ID_ARITH_CFG);
    end

endmodule

// File: core/priv_check.sv
// privilege check of one decoded instruction against the current level
// assumes the decoder has already judged opcode and register validity
`timescale 1ns/1ps
module priv_check
(
    input  wire logic [7:0]          i_op,
    input  wire logic                i_priv,
    input  wire dec_pkg::form_t      i_tgt_form,
    input  wire dec_pkg::reg_class_t i_tgt,
    input  wire logic [7:0]          i_tgt_id,
    input  wire logic [7:0]          i_vector,
    input  wire logic [31:0]         i_vec_mask,
    input  wire logic                i_bad,
    output dec_pkg::fault_t          o_fault
);
    import dec_pkg::*;

    logic writes_tgt;
    logic vec_needs_l0;
    logic [7:0] vec_off;

    always_comb
    begin
        vec_off    = i_vector - ARCH_VEC_NUM;
        writes_tgt = (i_op == copy_register_op) || (i_op == copy_literal_op) || (i_op == copy_memory_op)
                     || (i_op == arithmetic_op) || (i_op == logic_op);
        // (RULE10) architecture vectors only from level 0
        vec_needs_l0 = (i_vector < ARCH_VEC_NUM)
                       || ((i_vector <= USER_VEC_LAST) && i_vec_mask[vec_off[4:0]]);
        o_fault = FAULT_NONE;
        // (RULE16) malformed word faults first
        if (i_bad)
            o_fault = FAULT_ILLEGAL;
        // (RULE9) task load barred at level 1
        else if (i_priv && (i_op == task_load_op))
            o_fault = FAULT_ILLEGAL;
        // (RULE11) software interrupt at level 1
        else if (i_priv && (i_op == software_interrupt_op) && vec_needs_l0)
            o_fault = FAULT_PRIV;
        // (RULE7) pointer never written directly
        else if (writes_tgt && (i_tgt_form == FORM_REG) && (i_tgt_id == ID_IP))
            o_fault = FAULT_WRITE;
        // (RULE8) level 1 write filter
        else if (writes_tgt && (i_tgt_form == FORM_REG) && i_priv && !i_tgt.user_wr)
            o_fault = FAULT_WRITE;
    end

endmodule

// File: bench/risc_decode_privilege_sva.sv
// checker: port relations of the instruction decoder
// assumes a bind onto risc_decode_privilege, one clock domain
`timescale 1ns/1ps
module risc_decode_privilege_sva
    import dec_pkg::*;
(
    input wire logic             i_mclk,
    input wire logic             i_rstn,
    input wire logic             i_word_valid,
    input wire logic [31:0]      i_word,
    input wire logic             o_word_ready,
    input wire dec_pkg::uop_t    o_uop,
    input wire logic             o_uop_valid,
    input wire logic             i_uop_ready,
    input wire dec_pkg::av_req_t i_av,
    input wire dec_pkg::av_rsp_t o_av,
    input wire logic             o_priv_level
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    wire ex = o_uop_valid && o_uop.kind == UOP_EXEC;
    priv_set_a:
    assert property (i_av.write && !o_av.waitrequest && i_av.address == OFS_CTRL
        |=> o_priv_level == $past(i_av.writedata[PRIV_BIT])) else $error("level not set by ctrl write");
    wait_pulse_a:
    assert property (!o_av.waitrequest |=> o_av.waitrequest) else $error("waitrequest low too long");
    op_known_a:
    assert property (ex |-> o_uop.op inside {[8'h01:8'h0E]}) else $error("unknown opcode executed");
    fault_code_a:
    assert property (o_uop_valid |-> (o_uop.kind == UOP_FAULT) == (o_uop.fault != FAULT_NONE))
        else $error("fault kind and code disagree");
    reg_id_a:
    assert property (ex && o_uop.src_form == FORM_REG |-> o_uop.src_id[1:0] == 2'b00 && o_uop.src_id <= ID_FP_LAST)
        else $error("bad source id executed");
    ip_target_a:
    assert property (ex && o_uop.tgt_form == FORM_REG |-> o_uop.tgt_id != ID_IP) else $error("pointer written");
    user_write_a:
    assert property (ex && o_priv_level && o_uop.op == copy_register_op && o_uop.tgt_form == FORM_REG
        |-> o_uop.tgt_id >= ID_STACK) else $error("user wrote control register");
    task_load_a:
    assert property (ex && o_uop.op == task_load_op |-> !o_priv_level) else $error("task load at level 1");
    uop_hold_a:
    assert property (o_uop_valid && !i_uop_ready |=> o_uop_valid && $stable(o_uop)) else $error("uop dropped");
    cover property (o_uop_valid && o_uop.kind == UOP_RESTORE);
    cover property (ex && o_priv_level);
    cover property (o_uop_valid && o_uop.fault == FAULT_PRIV);
endmodule
bind risc_decode_privilege risc_decode_privilege_sva chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_word_valid(i_word_valid), .i_word(i_word), .o_word_ready(o_word_ready), .o_uop(o_uop),
    .o_uop_valid(o_uop_valid), .i_uop_ready(i_uop_ready), .i_av(i_av), .o_av(o_av), .o_priv_level(o_priv_level));

// File: bench/risc_decode_privilege_test.sv
// bench: drives fetch, micro-op and avalon ports directly
// assumes dec_pkg and the decoder sources are compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module risc_decode_privilege_test;
    import dec_pkg::*;
    logic        i_mclk = 0, i_rstn = 0, i_word_valid = 0, i_uop_ready = 0, o_word_ready, o_uop_valid, o_priv_level;
    logic [31:0] i_word = '0, rd;
    av_req_t     i_av = '0;
    av_rsp_t     o_av;
    uop_t        o_uop, u;
    int          n_errors = 0, checked = 0;
    uop_kind_t   stg[8] = '{UOP_SAVE, UOP_SAVE, UOP_LOAD, UOP_LOAD, UOP_EXEC, UOP_WRBACK, UOP_RESTORE, UOP_RESTORE};
    // last six probe level rules: at level 1 task load, arch vector, control write and masked user vector fault; config write and open user vector do not
    logic [31:0] pw[14] = '{32'h8, 32'hD, 32'h0058_5405, 32'h4C06, 32'h3C07, 32'h0038_2004, 32'h0058_540A,
                            32'h0020_3003, 32'h300E, 32'h0A0B, 32'h0008_3001, 32'h0024_3001, 32'h210B, 32'h220B};
    fault_t      pf[14] = '{FAULT_NONE, FAULT_NONE, FAULT_NONE, FAULT_NONE, FAULT_NONE, FAULT_NONE, FAULT_NONE,
                            FAULT_NONE, FAULT_ILLEGAL, FAULT_PRIV, FAULT_WRITE, FAULT_NONE, FAULT_PRIV, FAULT_NONE};
    always #5 i_mclk = ~i_mclk;
    risc_decode_privilege uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_word_valid(i_word_valid), .i_word(i_word),
        .o_word_ready(o_word_ready), .o_uop(o_uop), .o_uop_valid(o_uop_valid), .i_uop_ready(i_uop_ready),
        .i_av(i_av), .o_av(o_av), .o_priv_level(o_priv_level));
    task automatic final_report;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // every wait is cut short after 200 cycles
    task automatic tick(inout int k);
        @(posedge i_mclk);
        k++;
        if (k > 200)
        begin
            n_errors++;
            final_report();
        end
    endtask
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k = 0;
        i_av <= '{read: !wr, write: wr, address: a, writedata: d};
        do tick(k); while (o_av.waitrequest !== 1'b0);
        rd = o_av.readdata;
        i_av <= '0;
        @(posedge i_mclk);
    endtask
    task automatic put(input logic [31:0] w);
        int k = 0;
        i_word_valid <= 1'b1;
        i_word <= w;
        do tick(k); while (o_word_ready !== 1'b1);
    endtask
    task automatic get;
        int k = 0;
        i_uop_ready <= 1'b1;
        do tick(k); while (o_uop_valid !== 1'b1);
        u = o_uop;
    endtask
    task automatic run(input logic [31:0] w, input fault_t f);
        put(w);
        i_word_valid <= 1'b0;
        get();
        i_uop_ready <= 1'b0;
        `CHK("kind", (f == FAULT_NONE) ? UOP_EXEC : UOP_FAULT, u.kind)
        `CHK("fault", f, u.fault)
    endtask
    initial
    begin
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        `CHK("level", 1'b0, o_priv_level)
        av(1'b0, OFS_CTRL, '0);
        `CHK("ctrl", 32'h0000_0001, rd)
        av(1'b0, 5'h10, '0);
        `CHK("unmapped", 32'h0, rd)
        put(32'h0050_5809);
        i_word_valid <= 1'b0;
        repeat (4) @(posedge i_mclk);
        get();
        i_uop_ready <= 1'b0;
        `CHK("alu", {UOP_EXEC, 8'h09, 8'h58, 8'h50}, {u.kind, u.op, u.src_id, u.tgt_id})
        put(32'h0034_3009);
        i_word_valid <= 1'b0;
        foreach (stg[i])
        begin
            get();
            `CHK("stage", stg[i], u.kind)
        end
        i_uop_ready <= 1'b0;
        put(32'h0050_0002);
        put(32'h0000_0012);
        i_word_valid <= 1'b0;
        get();
        i_uop_ready <= 1'b0;
        `CHK("literal", {FORM_LIT, 32'h12}, {u.src_form, u.ext0})
        run(32'h0000_000C, FAULT_NONE);
        run(32'h0000_000F, FAULT_ILLEGAL);
        run(32'h0071_3001, FAULT_ILLEGAL);
        run(32'h0150_5809, FAULT_ILLEGAL);
        run(32'h0064_6009, FAULT_NONE);
        `CHK("fp_mode", 1'b1, u.fp_mode)
        av(1'b0, OFS_FAULT, '0);
        `CHK("fault_reg", 3'h1, rd[2:0])
        av(1'b1, OFS_FAULT, 32'h7);
        av(1'b0, OFS_FAULT, '0);
        `CHK("fault_clr", 32'h0, rd)
        av(1'b1, OFS_VEC_MASK, 32'h2);
        for (int lv = 0; lv < 2; lv++)
        begin
            av(1'b1, OFS_CTRL, {28'h0, lv[0], 3'h1});
            `CHK("level", lv[0], o_priv_level)
            foreach (pw[i])
                run(pw[i], lv ? pf[i] : FAULT_NONE);
        end
        av(1'b0, OFS_FAULT, '0);
        `CHK("fault_reg", 3'h7, rd[2:0])
        final_report();
    end
endmodule
